// file: srf_cfg.svh
`ifndef SRF_CFG_SVH
`define SRF_CFG_SVH

// Register byte offsets
`define SRF_OFF_CTRL 8'h00
`define SRF_OFF_INSTR 8'h04
`define SRF_OFF_STATUS 8'h08
`define SRF_OFF_ACCUM 8'h0C
`define SRF_OFF_BANK 8'h10
`define SRF_OFF_PTR 8'h14
`define SRF_OFF_LATCH 8'h18
`define SRF_OFF_IP 8'h1C
`define SRF_OFF_IDXBASE 8'h20

// Control and status field positions
`define SRF_CTRL_GO 0
`define SRF_CTRL_EXT 1
`define SRF_ST_BUSY 0
`define SRF_ST_NEG 1
`define SRF_ST_ZERO 2
`define SRF_ST_UNK 3

// Reset values
`define SRF_RST_ACCUM 8'h00
`define SRF_RST_BANK 4'h0
`define SRF_RST_PTR 21'h000000
`define SRF_RST_IP 21'h000000
`define SRF_RST_INSTR 16'h0000
`define SRF_RST_IDXBASE 12'h000

// Opcodes
`define SRF_OP_DISCARD 16'h0006
`define SRF_OP_SAVE 16'h0005
`define SRF_OP_TBL_HI 14'h0002
`define SRF_OP_ROT_HI 6'h10
`define SRF_OP_FILL_HI 7'h34
`define SRF_OP_SECOND 4'hF
`define SRF_FILL_VALUE 8'hFF

// Addressing
`define SRF_IDX_LIMIT 8'h5F
`define SRF_ACCESS_HI_BANK 4'hF
`define SRF_ACCESS_LO_BANK 4'h0
`define SRF_IP_STEP 21'h000002

// Quarter phases, one oscillator period each
`define SRF_Q1 2'h0
`define SRF_Q2 2'h1
`define SRF_Q3 2'h2
`define SRF_Q4 2'h3

`endif

// file: srf_pkg.sv
package srf_pkg;

	// Execution sequencer states
	typedef enum logic [1:0] {
		SRF_IDLE,
		SRF_WAIT,
		SRF_CYC1,
		SRF_CYC2
	} srf_state_t;

	// Pointer update modes of the byte read
	typedef enum logic [1:0] {
		SRF_PM_KEEP,
		SRF_PM_POST_INC,
		SRF_PM_POST_DEC,
		SRF_PM_PRE_INC
	} srf_pm_mode_t;

endpackage : srf_pkg

// file: srf_qphase.sv
`timescale 1ns/1ps
`include "srf_cfg.svh"

module srf_qphase (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Phase
	output logic [1:0] qphase
);

	logic [1:0] qphase_q;

	// Free running quarter counter
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			qphase_q <= `SRF_Q1;
		end else begin
			qphase_q <= qphase_q + 2'h1;
		end
	end

	assign qphase = qphase_q;

endmodule : srf_qphase

// file: srf_addr_calc.sv
`timescale 1ns/1ps
`include "srf_cfg.svh"

module srf_addr_calc (
	// Instruction fields
	input wire logic [7:0] file_field,
	input wire logic access_bit,
	// Configuration
	input wire logic ext_en,
	input wire logic [3:0] bank_select,
	input wire logic [11:0] index_base,
	// Result
	output logic [11:0] file_addr
);

	wire indexed_mode;
	wire access_high;
	wire [11:0] indexed_addr;
	wire [11:0] access_addr;
	wire [11:0] banked_addr;

	// Mode selection
	assign indexed_mode = !access_bit && ext_en && (file_field <= `SRF_IDX_LIMIT);
	assign access_high = file_field > `SRF_IDX_LIMIT;
	assign indexed_addr = index_base + {4'h0, file_field};
	assign access_addr = access_high ? {`SRF_ACCESS_HI_BANK, file_field}
		: {`SRF_ACCESS_LO_BANK, file_field};
	assign banked_addr = {bank_select, file_field};

	// Final address
	assign file_addr = indexed_mode ? indexed_addr
		: (!access_bit ? access_addr : banked_addr);

endmodule : srf_addr_calc

// file: srf_top.sv
`timescale 1ns/1ps
`include "srf_cfg.svh"

// Contract
// - Discard pops return stack head, no flags
// - Save pushes instruction pointer plus two, no flags
// - Rotate right, bit0 to bit7, N Z
// - Destination bit 0 accumulator, 1 file
// - Access bit 0 access bank, 1 banked
// - Indexed offset when a=0, ext, f<=5Fh
// - Fill ones writes FFh, no flags
// - Byte read copies program byte to latch
// - Pointer bit 0 selects word byte
// - Mode field picks pointer update
// - Instruction cycle is four quarter phases
// - Second word alone behaves as nop
module srf_top
	import srf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Data register file
	output logic [11:0] rf_addr,
	output logic rf_rd_en,
	input wire logic [7:0] rf_rdata,
	output logic rf_wr_en,
	output logic [7:0] rf_wdata,
	// Program memory, word addressed
	output logic [19:0] pm_addr,
	output logic pm_rd_en,
	input wire logic [15:0] pm_rdata,
	// Return stack
	output logic rs_push,
	output logic rs_pop,
	output logic [20:0] rs_push_value
);

	srf_state_t state_q, state_d;
	logic [1:0] qphase;
	logic [15:0] instr_q;
	logic ext_en_q;
	logic [7:0] accum_q;
	logic [3:0] bank_q;
	logic [20:0] ptr_q;
	logic [7:0] latch_q;
	logic [20:0] ip_q;
	logic [11:0] idx_base_q;
	logic neg_q;
	logic zero_q;
	logic unk_q;
	logic [31:0] prdata_q;
	logic [11:0] rf_addr_q;
	logic rf_rd_en_q;
	logic rf_wr_en_q;
	logic [7:0] rf_wdata_q;
	logic [19:0] pm_addr_q;
	logic pm_rd_en_q;
	logic rs_push_q;
	logic rs_pop_q;
	logic [20:0] rs_value_q;
	logic [11:0] file_addr;

	// Quarter phase source
	srf_qphase u_qphase (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.qphase(qphase)
	);

	// Operand address former
	srf_addr_calc u_addr (
		.file_field(instr_q[7:0]),
		.access_bit(instr_q[8]),
		.ext_en(ext_en_q),
		.bank_select(bank_q),
		.index_base(idx_base_q),
		.file_addr(file_addr)
	);

	// Phase strobes
	wire q1 = qphase == `SRF_Q1;
	wire q2 = qphase == `SRF_Q2;
	wire q3 = qphase == `SRF_Q3;
	wire q4 = qphase == `SRF_Q4;
	wire busy = state_q != SRF_IDLE;
	wire in_c1 = state_q == SRF_CYC1;
	wire in_c2 = state_q == SRF_CYC2;

	// Instruction decode
	wire is_discard = instr_q == `SRF_OP_DISCARD;
	wire is_save = instr_q == `SRF_OP_SAVE;
	wire is_tbl = instr_q[15:2] == `SRF_OP_TBL_HI;
	wire is_rot = instr_q[15:10] == `SRF_OP_ROT_HI;
	wire is_fill = instr_q[15:9] == `SRF_OP_FILL_HI;
	wire is_second = instr_q[15:12] == `SRF_OP_SECOND;
	wire is_known = is_discard | is_save | is_tbl | is_rot | is_fill | is_second;
	wire dest_file = instr_q[9];
	wire [1:0] pm_mode = instr_q[1:0];
	wire file_op = is_rot | is_fill;

	// Data path
	wire [7:0] rot_value = {rf_rdata[0], rf_rdata[7:1]};
	wire [7:0] op_result = is_fill ? `SRF_FILL_VALUE : rot_value;
	wire [7:0] pm_byte = ptr_q[0] ? pm_rdata[15:8] : pm_rdata[7:0];
	wire [20:0] ptr_inc = ptr_q + 21'h000001;
	wire [20:0] ptr_dec = ptr_q - 21'h000001;
	wire [20:0] ip_next = ip_q + `SRF_IP_STEP;
	wire [20:0] ptr_upd = ((in_c1 && is_tbl && pm_mode == SRF_PM_PRE_INC)
		|| (in_c2 && pm_mode == SRF_PM_POST_INC)) ? ptr_inc
		: (in_c2 && pm_mode == SRF_PM_POST_DEC) ? ptr_dec : ptr_q;

	// APB decode
	wire apb_setup = psel && !penable;
	wire apb_wr = psel && penable && pwrite;
	wire hit_ctrl = paddr == `SRF_OFF_CTRL;
	wire hit_instr = paddr == `SRF_OFF_INSTR;
	wire hit_status = paddr == `SRF_OFF_STATUS;
	wire hit_accum = paddr == `SRF_OFF_ACCUM;
	wire hit_bank = paddr == `SRF_OFF_BANK;
	wire hit_ptr = paddr == `SRF_OFF_PTR;
	wire hit_latch = paddr == `SRF_OFF_LATCH;
	wire hit_ip = paddr == `SRF_OFF_IP;
	wire hit_idx = paddr == `SRF_OFF_IDXBASE;
	wire hit_any = hit_ctrl | hit_instr | hit_status | hit_accum | hit_bank
		| hit_ptr | hit_latch | hit_ip | hit_idx;
	wire sw_wr = apb_wr && !busy;
	wire go = apb_wr && hit_ctrl && pwdata[`SRF_CTRL_GO] && !busy;

	// Status word
	wire [31:0] status_word = {28'h0000000, unk_q, zero_q, neg_q, busy};

	// Read mux
	wire [31:0] rd_mux = hit_ctrl ? {30'h0, ext_en_q, 1'b0}
		: hit_instr ? {16'h0000, instr_q}
		: hit_status ? status_word
		: hit_accum ? {24'h000000, accum_q}
		: hit_bank ? {28'h0000000, bank_q}
		: hit_ptr ? {11'h000, ptr_q}
		: hit_latch ? {24'h000000, latch_q}
		: hit_ip ? {11'h000, ip_q}
		: hit_idx ? {20'h00000, idx_base_q}
		: 32'h00000000;

	// Sequencer: start on Q1, byte read takes two cycles
	always_comb begin
		state_d = state_q;
		case (state_q)
			SRF_IDLE: begin
				if (go) begin
					state_d = SRF_WAIT;
				end
			end
			SRF_WAIT: begin
				if (q4) begin
					state_d = SRF_CYC1;
				end
			end
			SRF_CYC1: begin
				if (q4) begin
					state_d = is_tbl ? SRF_CYC2 : SRF_IDLE;
				end
			end
			SRF_CYC2: begin
				if (q4) begin
					state_d = SRF_IDLE;
				end
			end
			default: begin
				state_d = SRF_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_q <= SRF_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// APB read data, captured in setup phase
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prdata_q <= 32'h00000000;
		end else if (apb_setup) begin
			prdata_q <= rd_mux;
		end
	end

	// Software configuration registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			instr_q <= `SRF_RST_INSTR;
			ext_en_q <= 1'b0;
			bank_q <= `SRF_RST_BANK;
			idx_base_q <= `SRF_RST_IDXBASE;
		end else if (sw_wr) begin
			if (hit_instr) begin
				instr_q <= pwdata[15:0];
			end
			if (hit_ctrl) begin
				ext_en_q <= pwdata[`SRF_CTRL_EXT];
			end
			if (hit_bank) begin
				bank_q <= pwdata[3:0];
			end
			if (hit_idx) begin
				idx_base_q <= pwdata[11:0];
			end
		end
	end

	// Accumulator and flags
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			accum_q <= `SRF_RST_ACCUM;
			neg_q <= 1'b0;
			zero_q <= 1'b0;
			unk_q <= 1'b0;
		end else begin
			if (sw_wr && hit_accum) begin
				accum_q <= pwdata[7:0];
			end
			if (go) begin
				unk_q <= 1'b0;
			end
			if (in_c1 && q1 && !is_known) begin
				unk_q <= 1'b1;
			end
			if (in_c1 && q3 && is_rot) begin
				neg_q <= op_result[7];
				zero_q <= op_result == 8'h00;
				if (!dest_file) begin
					accum_q <= op_result;
				end
			end
		end
	end

	// Register file strobes: read in Q2, write in Q4
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rf_addr_q <= 12'h000;
			rf_rd_en_q <= 1'b0;
			rf_wr_en_q <= 1'b0;
			rf_wdata_q <= 8'h00;
		end else begin
			rf_rd_en_q <= in_c1 && q1 && file_op;
			rf_wr_en_q <= in_c1 && q3 && (is_fill || (is_rot && dest_file));
			if (in_c1 && q1) begin
				rf_addr_q <= file_addr;
			end
			if (in_c1 && q3) begin
				rf_wdata_q <= op_result;
			end
		end
	end

	// Return stack strobes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rs_push_q <= 1'b0;
			rs_pop_q <= 1'b0;
			rs_value_q <= 21'h000000;
		end else begin
			rs_push_q <= in_c1 && q1 && is_save;
			rs_pop_q <= in_c1 && q2 && is_discard;
			if (in_c1 && q1) begin
				rs_value_q <= ip_next;
			end
		end
	end

	// Program memory read in second cycle Q2
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pm_addr_q <= 20'h00000;
			pm_rd_en_q <= 1'b0;
			latch_q <= 8'h00;
		end else begin
			pm_rd_en_q <= in_c2 && q1;
			if (in_c2 && q1) begin
				pm_addr_q <= ptr_q[20:1];
			end
			if (in_c2 && q3) begin
				latch_q <= pm_byte;
			end
		end
	end

	// Pointer updates and instruction pointer advance
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ptr_q <= `SRF_RST_PTR;
			ip_q <= `SRF_RST_IP;
		end else begin
			if (sw_wr && hit_ptr) begin
				ptr_q <= pwdata[20:0];
			end
			if (sw_wr && hit_ip) begin
				ip_q <= pwdata[20:0];
			end
			if (busy && q4) begin
				ptr_q <= ptr_upd;
			end
			if ((in_c1 && q4 && !is_tbl) || (in_c2 && q4)) begin
				ip_q <= ip_next;
			end
		end
	end

	// Output drive
	assign prdata = prdata_q;
	assign pready = psel && penable;
	assign pslverr = psel && penable && !hit_any;
	assign rf_addr = rf_addr_q;
	assign rf_rd_en = rf_rd_en_q;
	assign rf_wr_en = rf_wr_en_q;
	assign rf_wdata = rf_wdata_q;
	assign pm_addr = pm_addr_q;
	assign pm_rd_en = pm_rd_en_q;
	assign rs_push = rs_push_q;
	assign rs_pop = rs_pop_q;
	assign rs_push_value = rs_value_q;

endmodule : srf_top

// file: srf_assertions.sv
`timescale 1ns/1ps
module srf_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Bus handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Far side strobes
	input wire logic [11:0] rf_addr,
	input wire logic rf_rd_en,
	input wire logic rf_wr_en,
	input wire logic pm_rd_en,
	input wire logic rs_push,
	input wire logic rs_pop
);
	// One clock domain throughout
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	zero_wait_a: assert property (psel && penable |-> pready)
		else $error("access without ready");
	err_in_access_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	push_pulse_a: assert property (rs_push |=> !rs_push)
		else $error("push longer than a cycle");
	pop_pulse_a: assert property (rs_pop |=> !rs_pop [*3])
		else $error("pop repeated");
	push_pop_excl_a: assert property (!(rs_push && rs_pop))
		else $error("push and pop together");
	read_then_write_a: assert property (rf_wr_en |-> $past(rf_rd_en, 2))
		else $error("write not two phases after read");
	write_same_addr_a: assert property (rf_wr_en |-> rf_addr == $past(rf_addr, 2))
		else $error("write address moved");
	single_fetch_a: assert property (pm_rd_en |=> !pm_rd_en [*6])
		else $error("second program fetch");
endmodule : srf_assertions

// file: srf_partner.sv
`timescale 1ns/1ps
module srf_partner (
	// Clock
	input wire logic sys_clk,
	// Register file
	input wire logic [11:0] rf_addr,
	input wire logic rf_rd_en,
	input wire logic rf_wr_en,
	input wire logic [7:0] rf_wdata,
	output logic [7:0] rf_rdata,
	// Program memory
	input wire logic [19:0] pm_addr,
	input wire logic pm_rd_en,
	output logic [15:0] pm_rdata,
	// Return stack
	input wire logic rs_push,
	input wire logic rs_pop,
	input wire logic [20:0] rs_push_value
);
	logic [7:0] mem_q [4096];
	logic [20:0] stack_q [$];

	// Known contents so the bench can predict them
	initial begin
		rf_rdata = 8'h00;
		pm_rdata = 16'h0000;
		foreach (mem_q[i]) mem_q[i] = i[7:0] ^ 8'hA5;
	end

	// Synchronous reads; idle data toggles so stale values never match
	always @(posedge sys_clk) begin
		rf_rdata <= rf_rd_en ? mem_q[rf_addr] : ~rf_rdata;
		pm_rdata <= pm_rd_en ? {~pm_addr[7:0], pm_addr[7:0]} : ~pm_rdata;
		if (rf_wr_en) mem_q[rf_addr] <= rf_wdata;
		if (rs_push) stack_q.push_front(rs_push_value);
		if (rs_pop && stack_q.size() > 0) void'(stack_q.pop_front());
	end
endmodule : srf_partner

// file: srf_top_tb.sv
`timescale 1ns/1ps
`include "srf_cfg.svh"
module srf_top_tb;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, rf_rd_en, rf_wr_en, pm_rd_en, rs_push, rs_pop, err;
	logic [11:0] rf_addr, x;
	logic [7:0] rf_rdata, rf_wdata, f, v;
	logic [19:0] pm_addr;
	logic [15:0] pm_rdata;
	logic [20:0] rs_push_value, p, q;
	logic [3:0] b;
	logic [32:0] note_q [$];
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	srf_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rf_addr(rf_addr), .rf_rd_en(rf_rd_en),
		.rf_rdata(rf_rdata), .rf_wr_en(rf_wr_en), .rf_wdata(rf_wdata), .pm_addr(pm_addr),
		.pm_rd_en(pm_rd_en), .pm_rdata(pm_rdata), .rs_push(rs_push), .rs_pop(rs_pop),
		.rs_push_value(rs_push_value));
	srf_partner partner_u (.sys_clk(sys_clk), .rf_addr(rf_addr), .rf_rd_en(rf_rd_en),
		.rf_wr_en(rf_wr_en), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .pm_addr(pm_addr),
		.pm_rd_en(pm_rd_en), .pm_rdata(pm_rdata), .rs_push(rs_push), .rs_pop(rs_pop),
		.rs_push_value(rs_push_value));

	always #2.5 sys_clk = ~sys_clk;

	task automatic tally_and_finish;
		if (num_errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish

	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : cmp

	// One APB transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp({err, rd}, {1'b0, e});
	endtask : chk

	// Load, start, poll until idle; rd keeps the last status
	task automatic run(input logic [15:0] op, input logic ext);
		apb(1'b1, `SRF_OFF_INSTR, {16'h0, op});
		apb(1'b1, `SRF_OFF_CTRL, {30'h0, ext, 1'b1});
		repeat (8) begin
			apb(1'b0, `SRF_OFF_STATUS, 32'h0);
			if (rd[0] === 1'b0) break;
		end
	endtask : run

	// Match each write or push with the oldest note
	always @(posedge sys_clk) begin
		if (rf_wr_en === 1'b1 || rs_push === 1'b1)
			cmp(rs_push ? {1'b1, 11'h0, rs_push_value} : {13'h0, rf_addr, rf_wdata},
				note_q.size() > 0 ? note_q.pop_front() : '1);
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	initial begin
		void'($urandom(14123));
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		// Reset values, then an unmapped place
		for (int i = 0; i < 9; i++) chk(8'(i * 4), 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		cmp({err, rd}, 33'h100000000);
		// Push two return addresses, then drop them one by one
		p = 21'($urandom) & 21'h1FFFFE;
		apb(1'b1, `SRF_OFF_IP, 32'(p));
		note_q.push_back({1'b1, 11'h0, p + 21'h2});
		run(`SRF_OP_SAVE, 1'b0);
		cmp({err, rd}, 33'h0);
		note_q.push_back({1'b1, 11'h0, p + 21'h4});
		run(`SRF_OP_SAVE, 1'b0);
		run(`SRF_OP_DISCARD, 1'b0);
		cmp({err, rd}, 33'h0);
		cmp(33'(partner_u.stack_q.size()), 33'h1);
		cmp({12'h0, partner_u.stack_q[0]}, {12'h0, p + 21'h2});
		run(`SRF_OP_DISCARD, 1'b0);
		cmp(33'(partner_u.stack_q.size()), 33'h0);
		chk(`SRF_OFF_IP, {11'h0, p + 21'h8});
		// Rotate banked write-back, then accumulator, then access bank
		b = 4'($urandom);
		f = 8'($urandom);
		v = f ^ 8'hA5;
		apb(1'b1, `SRF_OFF_BANK, 32'(b));
		note_q.push_back({13'h0, b, f, v[0], v[7:1]});
		run({6'h10, 2'b11, f}, 1'b0);
		cmp({err, rd}, {30'h0, v == 8'h00, v[0], 1'b0});
		run({6'h10, 2'b00, 8'hA4}, 1'b0);
		cmp({err, rd}, 33'h2);
		chk(`SRF_OFF_ACCUM, 32'h80);
		note_q.push_back({13'h0, 12'hFA5, 8'h00});
		run({6'h10, 2'b10, 8'hA5}, 1'b1);
		cmp({err, rd}, 33'h4);
		// Fill in access bank, indexed offset and banked forms
		x = 12'($urandom);
		apb(1'b1, `SRF_OFF_IDXBASE, 32'(x));
		note_q.push_back({13'h0, 12'h05F, 8'hFF});
		run({7'h34, 1'b0, 8'h5F}, 1'b0);
		note_q.push_back({13'h0, x + 12'h05F, 8'hFF});
		run({7'h34, 1'b0, 8'h5F}, 1'b1);
		note_q.push_back({13'h0, b, f, 8'hFF});
		run({7'h34, 1'b1, f}, 1'b1);
		cmp({err, rd}, 33'h4);
		// Byte read in every pointer mode, both bytes of a word
		for (int m = 0; m < 4; m++) begin
			p = {20'($urandom), m[0]};
			apb(1'b1, `SRF_OFF_PTR, 32'(p));
			run({14'h0002, 2'(m)}, 1'b0);
			q = (m == 3) ? p + 21'h1 : p;
			chk(`SRF_OFF_LATCH, {24'h0, q[0] ? ~q[8:1] : q[8:1]});
			q = m[0] ? p + 21'h1 : (m == 2) ? p - 21'h1 : p;
			chk(`SRF_OFF_PTR, 32'(q));
		end
		// Unknown opcode, then a lone second word
		run(16'h0007, 1'b0);
		cmp({err, rd}, 33'hC);
		run(16'hF123, 1'b0);
		cmp({err, rd}, 33'h4);
		cmp(33'(note_q.size()), 33'h0);
		tally_and_finish();
	end
endmodule : srf_top_tb

bind srf_top srf_assertions chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .rf_addr(rf_addr),
	.rf_rd_en(rf_rd_en), .rf_wr_en(rf_wr_en), .pm_rd_en(pm_rd_en), .rs_push(rs_push),
	.rs_pop(rs_pop));
